// >>> src/epsm_pin_stage.sv
`default_nettype none
module epsm_pin_stage (
    input  wire logic [3:0] own,
    input  wire logic [3:0] act_lvl,
    input  wire logic [3:0] pol_low,
    input  wire logic       sd_force,
    input  wire logic [1:0] sd_ac,
    input  wire logic [1:0] sd_bd,
    input  wire logic [3:0] port_latch,
    input  wire logic [3:0] port_drive,
    output logic      [3:0] pin_out,
    output logic      [3:0] pin_oe
);
    import epsm_pkg::*;

    // ****************************************************************
    // Per pin output mux
    // ****************************************************************
    // Shutdown is combinational so it acts without waiting for a clock
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_pin
            logic [1:0] sd_st;
            assign sd_st = (gi % 2 == 0) ? sd_ac : sd_bd;
            // RULE_20 pair shutdown state
            assign pin_out[gi] = !own[gi] ? port_latch[gi]
                               : sd_force ? sd_st[0] : (act_lvl[gi] ^ pol_low[gi]);
            assign pin_oe[gi]  = port_drive[gi] && !(own[gi] && sd_force && sd_st[SD_TRI_BIT]);
        end
    endgenerate
endmodule
`default_nettype wire

// >>> src/epsm_pkg.sv
`default_nettype none
package epsm_pkg;
    // ****************************************************************
    // Register map and field layout
    // ****************************************************************
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  OFF_MODE      = 8'h00;
    localparam logic [7:0]  OFF_STEER     = 8'h04;
    localparam logic [7:0]  OFF_SDCTL     = 8'h08;
    localparam logic [7:0]  OFF_DUTYH     = 8'h0C;
    localparam logic [7:0]  OFF_FLAGS     = 8'h10;
    localparam logic [7:0]  MODE_RST      = 8'h00;
    localparam logic [7:0]  STEER_RST     = 8'h01;
    localparam logic [7:0]  SDCTL_RST     = 8'h00;
    localparam logic [7:0]  DUTYH_RST     = 8'h00;
    localparam int unsigned CFG_MSB       = 7;
    localparam int unsigned CFG_LSB       = 6;
    localparam int unsigned DLO_MSB       = 5;
    localparam int unsigned DLO_LSB       = 4;
    localparam int unsigned SEL_MSB       = 3;
    localparam int unsigned STEER_SYNC    = 4;
    localparam int unsigned SD_STAT       = 7;
    localparam int unsigned SD_RSEN       = 6;
    localparam int unsigned SD_AC_MSB     = 3;
    localparam int unsigned SD_AC_LSB     = 2;
    localparam int unsigned SD_BD_MSB     = 1;
    localparam int unsigned SD_TRI_BIT    = 1;
    localparam int unsigned FLG_UNIT      = 0;
    localparam int unsigned FLG_PER       = 1;
    // ****************************************************************
    // Mode and configuration codes
    // ****************************************************************
    localparam logic [3:0]  MS_OFF        = 4'h0;
    localparam logic [3:0]  MS_TOGGLE     = 4'h2;
    localparam logic [3:0]  MS_CAP_FALL   = 4'h4;
    localparam logic [3:0]  MS_CAP_RISE   = 4'h5;
    localparam logic [3:0]  MS_CAP_4      = 4'h6;
    localparam logic [3:0]  MS_CAP_16     = 4'h7;
    localparam logic [3:0]  MS_CMP_SET    = 4'h8;
    localparam logic [3:0]  MS_CMP_CLR    = 4'h9;
    localparam logic [3:0]  MS_CMP_SW     = 4'hA;
    localparam logic [3:0]  MS_TRIG       = 4'hB;
    localparam logic [1:0]  UPPER_PWM     = 2'b11;
    localparam logic [1:0]  CFG_SINGLE    = 2'b00;
    localparam logic [1:0]  CFG_FWD       = 2'b01;
    localparam logic [1:0]  CFG_HALF      = 2'b10;
    localparam logic [1:0]  CFG_REV       = 2'b11;
    localparam logic [3:0]  CAP4_LAST     = 4'h3;
    localparam logic [3:0]  CAP16_LAST    = 4'hF;
    localparam logic [1:0]  PER_FULL      = 2'h2;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    typedef enum logic [2:0] {FN_OFF, FN_RSVD, FN_CAPTURE, FN_COMPARE, FN_PWM} epsm_func_e;
endpackage
`default_nettype wire

// >>> src/epsm_top.sv
// Behaviour
// RULE_01: Upper mode bits 11 with configuration 00 select single-output steering.
// RULE_02: Each steer enable routes the same PWM signal to its own pin.
// RULE_03: In steering, low mode bits set polarity of the steered pins.
// RULE_04: Shutdown forces only pins whose steer enable is set.
// RULE_05: Firmware sets at least one steer enable to see PWM anywhere.
// RULE_06: Sync bit 0 applies a steering write immediately, possibly truncating.
// RULE_07: Sync bit 1 holds a steering write until next period start.
// RULE_08: Codes 1100-1111: bit0 makes B/D active-low, bit1 makes A/C active-low.
// RULE_09: Period flag is set as the second PWM period begins.
// RULE_10: Firmware waits one full PWM cycle before enabling pin drivers.
// RULE_11: Firmware chooses polarity before enabling pin drivers.
// RULE_12: Config 00 single, 01 forward bridge, 10 half bridge, 11 reverse.
// RULE_13: Non-PWM modes keep A for capture/compare, B/C/D return to port.
// RULE_14: Duty low bits form the two LSBs below the duty high byte.
// RULE_15: Code 0000 turns off and resets; 0001 and 0011 do nothing.
// RULE_16: Capture codes: falling, rising, every 4th, every 16th rising edge.
// RULE_17: Compare codes: toggle, set, clear, flag only; 1000-1010 set flag.
// RULE_18: Code 1011 resets timer, sets flag, second unit starts conversion.
// RULE_19: Simple units take any 11xx as PWM with no configuration bits.
// RULE_20: Shutdown sets status and forces pairs low, high or tri-state.
// RULE_21: Unsteered pins in single mode fall back to the port latch.
`default_nettype none
module epsm_top #(
    parameter bit ENHANCED    = 1'b1,
    parameter bit SECOND_UNIT = 1'b0
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [epsm_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                 awprot,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    input  wire logic [epsm_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                 arprot,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    input  wire logic                       pwm_in,
    input  wire logic                       period_start,
    input  wire logic                       compare_match,
    input  wire logic                       cap_in,
    input  wire logic                       shutdown_req,
    input  wire logic                       adc_enable,
    input  wire logic [3:0]                 port_latch,
    input  wire logic [3:0]                 port_drive,
    output logic [3:0]                      pin_out,
    output logic [3:0]                      pin_oe,
    output logic [9:0]                      duty_value,
    output logic                            capture_strobe,
    output logic                            timer_reset,
    output logic                            adc_start
);
    import epsm_pkg::*;

    logic [7:0] mode_r, steer_r, steer_act_r, sdctl_r, dutyh_r;
    logic [1:0] flags_r;
    logic       aw_hold_r, w_hold_r, wstrb0_r;
    logic [7:0] aw_addr_r, w_data_r;
    logic       wr_fire;
    logic [1:0] per_cnt_r;
    logic       pwm_run_r, cmp_pin_r, cap_prev_r;
    logic [3:0] cap_cnt_r;
    logic [3:0] own, act_lvl, pol_low;
    logic       sd_force, steering, cap_hit;
    epsm_func_e func;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == OFF_MODE) || (a == OFF_STEER) || (a == OFF_SDCTL)
               || (a == OFF_DUTYH) || (a == OFF_FLAGS);
    endfunction

    function automatic epsm_func_e mode_func(input logic [3:0] m);
        unique case (m)
            4'h0:                   mode_func = FN_OFF;
            4'h1, 4'h3:             mode_func = FN_RSVD;
            4'h2, 4'h8, 4'h9, 4'hA, 4'hB: mode_func = FN_COMPARE;
            4'h4, 4'h5, 4'h6, 4'h7: mode_func = FN_CAPTURE;
            4'hC, 4'hD, 4'hE, 4'hF: mode_func = FN_PWM;
        endcase
    endfunction

    assign func     = mode_func(mode_r[SEL_MSB:0]);
    // RULE_01 steering select
    assign steering = (func == FN_PWM) && (!ENHANCED || mode_r[CFG_MSB:CFG_LSB] == CFG_SINGLE);

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    // Address and data are caught separately so either may come first
    assign awready = !aw_hold_r && !bvalid;
    assign wready  = !w_hold_r && !bvalid;
    assign wr_fire = aw_hold_r && w_hold_r && !bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 8'h00;
            wstrb0_r  <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_hold_r <= 1'b1;
                w_data_r <= wdata[7:0];
                wstrb0_r <= wstrb[0];
            end
            if (wr_fire)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= reg_hit(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    assign arready = !rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp  <= reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr)
                OFF_MODE:  rdata <= {24'h00_0000, mode_r};
                OFF_STEER: rdata <= {24'h00_0000, steer_r};
                OFF_SDCTL: rdata <= {24'h00_0000, sdctl_r};
                OFF_DUTYH: rdata <= {24'h00_0000, dutyh_r};
                OFF_FLAGS: rdata <= {30'h0000_0000, flags_r};
                default:   rdata <= 32'h0000_0000;
            endcase
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_r  <= MODE_RST;
            dutyh_r <= DUTYH_RST;
        end
        else if (wr_fire && wstrb0_r)
        begin
            // RULE_19 simple unit config
            if (aw_addr_r == OFF_MODE)
                mode_r <= ENHANCED ? w_data_r : {2'b00, w_data_r[DLO_MSB:0]};
            if (aw_addr_r == OFF_DUTYH)
                dutyh_r <= w_data_r;
        end
    end

    // RULE_14 ten-bit duty
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            duty_value <= 10'h000;
        else
            duty_value <= {dutyh_r, mode_r[DLO_MSB:DLO_LSB]};
    end

    // ****************************************************************
    // Steering register and its update point
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            steer_r     <= STEER_RST;
            steer_act_r <= STEER_RST;
        end
        else
        begin
            if (wr_fire && wstrb0_r && aw_addr_r == OFF_STEER)
                steer_r <= {3'b000, w_data_r[STEER_SYNC:0]};
            // RULE_06 immediate steering
            if (wr_fire && wstrb0_r && aw_addr_r == OFF_STEER && !w_data_r[STEER_SYNC])
                steer_act_r <= {3'b000, w_data_r[STEER_SYNC:0]};
            // RULE_07 period aligned steering
            else if (period_start && steer_r[STEER_SYNC])
                steer_act_r <= steer_r;
        end
    end

    // ****************************************************************
    // Shutdown status
    // ****************************************************************
    // Firmware writes to the status bit are ignored while the request is up
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sdctl_r <= SDCTL_RST;
        else
        begin
            if (wr_fire && wstrb0_r && aw_addr_r == OFF_SDCTL)
                sdctl_r <= shutdown_req ? {sdctl_r[SD_STAT], w_data_r[SD_RSEN:0]} : w_data_r;
            // RULE_20 status set wins
            if (shutdown_req && func == FN_PWM)
                sdctl_r[SD_STAT] <= 1'b1;
            else if (sdctl_r[SD_RSEN] && !(wr_fire && aw_addr_r == OFF_SDCTL && wstrb0_r))
                sdctl_r[SD_STAT] <= 1'b0;
        end
    end

    // Restart only on a period boundary so no runt pulse reaches the bridge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pwm_run_r <= 1'b1;
        else if (sdctl_r[SD_STAT] || shutdown_req)
            pwm_run_r <= 1'b0;
        else if (period_start)
            pwm_run_r <= 1'b1;
    end

    assign sd_force = (func == FN_PWM) && (shutdown_req || sdctl_r[SD_STAT] || !pwm_run_r);

    // ****************************************************************
    // Period flag and compare or capture events
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn || func != FN_PWM)
            per_cnt_r <= 2'h0;
        else if (period_start && per_cnt_r != PER_FULL)
            per_cnt_r <= per_cnt_r + 2'h1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flags_r <= 2'b00;
        else
        begin
            if (wr_fire && wstrb0_r && aw_addr_r == OFF_FLAGS)
                flags_r <= flags_r & ~w_data_r[1:0];
            // RULE_09 second period flag
            if (func == FN_PWM && period_start && per_cnt_r != 2'h0)
                flags_r[FLG_PER] <= 1'b1;
            // RULE_17 compare flag
            if (compare_match && mode_r[SEL_MSB:0] >= MS_CMP_SET
                && mode_r[SEL_MSB:0] <= MS_TRIG)
                flags_r[FLG_UNIT] <= 1'b1;
            if (cap_hit)
                flags_r[FLG_UNIT] <= 1'b1;
        end
    end

    // Initial level of the set and clear modes is taken on the mode write
    logic cmp_init;
    assign cmp_init = wr_fire && wstrb0_r && aw_addr_r == OFF_MODE;

    // RULE_17 compare pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cmp_pin_r <= 1'b0;
        else if (cmp_init && (w_data_r[SEL_MSB:0] == MS_CMP_SET
                 || w_data_r[SEL_MSB:0] == MS_CMP_CLR))
            cmp_pin_r <= (w_data_r[SEL_MSB:0] == MS_CMP_CLR);
        else if (mode_r[SEL_MSB:0] == MS_OFF)
            cmp_pin_r <= 1'b0;
        else if (mode_r[SEL_MSB:0] == MS_TOGGLE && compare_match)
            cmp_pin_r <= !cmp_pin_r;
        else if (mode_r[SEL_MSB:0] == MS_CMP_SET)
            cmp_pin_r <= compare_match ? 1'b1 : cmp_pin_r;
        else if (mode_r[SEL_MSB:0] == MS_CMP_CLR)
            cmp_pin_r <= compare_match ? 1'b0 : cmp_pin_r;
    end

    // RULE_18 special event trigger
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_reset <= 1'b0;
            adc_start   <= 1'b0;
        end
        else
        begin
            timer_reset <= compare_match && mode_r[SEL_MSB:0] == MS_TRIG;
            adc_start   <= compare_match && mode_r[SEL_MSB:0] == MS_TRIG
                           && SECOND_UNIT && adc_enable;
        end
    end

    // RULE_16 capture edge select
    always_comb
    begin
        unique case (mode_r[SEL_MSB:0])
            MS_CAP_FALL: cap_hit = cap_prev_r && !cap_in;
            MS_CAP_RISE: cap_hit = !cap_prev_r && cap_in;
            MS_CAP_4:    cap_hit = !cap_prev_r && cap_in && cap_cnt_r[1:0] == CAP4_LAST[1:0];
            MS_CAP_16:   cap_hit = !cap_prev_r && cap_in && cap_cnt_r == CAP16_LAST;
            default:     cap_hit = 1'b0;
        endcase
    end

    // RULE_15 off resets prescaler
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cap_prev_r <= 1'b0;
            cap_cnt_r  <= 4'h0;
        end
        // Track the pin while idle so entering capture sees no false edge
        else if (func != FN_CAPTURE)
        begin
            cap_prev_r <= cap_in;
            cap_cnt_r  <= 4'h0;
        end
        else
        begin
            cap_prev_r <= cap_in;
            if (!cap_prev_r && cap_in)
                cap_cnt_r <= cap_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            capture_strobe <= 1'b0;
        else
            capture_strobe <= cap_hit;
    end

    // ****************************************************************
    // Output routing per mode
    // ****************************************************************
    always_comb
    begin
        own     = 4'b0000;
        act_lvl = 4'b0000;
        pol_low = 4'b0000;
        // RULE_13 capture compare on A
        if (func == FN_COMPARE && mode_r[SEL_MSB:0] != MS_CMP_SW
            && mode_r[SEL_MSB:0] != MS_TRIG)
        begin
            own[0]     = 1'b1;
            act_lvl[0] = cmp_pin_r;
        end
        else if (func == FN_PWM && !ENHANCED)
        begin
            own[0]     = 1'b1;
            act_lvl[0] = pwm_in;
        end
        else if (func == FN_PWM)
        begin
            // RULE_03 steered pin polarity
            // RULE_08 pair polarity
            pol_low = {mode_r[0], mode_r[1], mode_r[0], mode_r[1]};
            // RULE_12 configuration decode
            unique case (mode_r[CFG_MSB:CFG_LSB])
                CFG_SINGLE:
                begin
                    // RULE_02 steer enables
                    // RULE_21 unsteered to port
                    own     = steer_act_r[3:0];
                    act_lvl = {4{pwm_in}};
                end
                CFG_FWD:
                begin
                    own     = 4'b1111;
                    act_lvl = {pwm_in, 1'b0, 1'b0, 1'b1};
                end
                CFG_HALF:
                begin
                    own     = 4'b0011;
                    act_lvl = {1'b0, 1'b0, !pwm_in, pwm_in};
                end
                CFG_REV:
                begin
                    own     = 4'b1111;
                    act_lvl = {1'b0, 1'b1, pwm_in, 1'b0};
                end
            endcase
        end
    end

    // RULE_04 shutdown on owned pins
    epsm_pin_stage u_pins (
        .own        (own),
        .act_lvl    (act_lvl),
        .pol_low    (pol_low),
        .sd_force   (sd_force),
        .sd_ac      (sdctl_r[SD_AC_MSB:SD_AC_LSB]),
        .sd_bd      (sdctl_r[SD_BD_MSB:0]),
        .port_latch (port_latch),
        .port_drive (port_drive),
        .pin_out    (pin_out),
        .pin_oe     (pin_oe)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    steer_now_a: assert property (wr_fire && wstrb0_r && aw_addr_r == OFF_STEER // RULE_06
        && !w_data_r[STEER_SYNC] |=> steer_act_r[3:0] == $past(w_data_r[3:0]))
        else $error("immediate steering not applied");
    steer_hold_a: assert property (steer_r[STEER_SYNC] && !period_start && !wr_fire // RULE_07
        |=> $stable(steer_act_r))
        else $error("synchronised steering moved mid period");
    per_flag_a: assert property ($rose(flags_r[FLG_PER]) // RULE_09
        |-> $past(period_start) && $past(per_cnt_r) != 2'h0)
        else $error("period flag set before second period");
    steer_pol_a: assert property (steering && ENHANCED && own[0] && !sd_force // RULE_03
        |-> pin_out[0] == (pwm_in ^ mode_r[1]))
        else $error("steered pin A polarity wrong");
    steer_only_a: assert property (steering && !steer_act_r[2] // RULE_21
        |-> pin_out[2] == port_latch[2])
        else $error("unsteered pin C not at port latch");
    sd_force_a: assert property (own[1] && sd_force && sdctl_r[SD_BD_MSB:0] == 2'b01 // RULE_20
        |-> pin_out[1] && pin_oe[1] == port_drive[1])
        else $error("pin B not forced high in shutdown");
    sd_status_a: assert property (shutdown_req && func == FN_PWM // RULE_20
        |=> sdctl_r[SD_STAT])
        else $error("shutdown status not set");
    port_rev_a: assert property (func != FN_PWM // RULE_13
        |-> pin_out[3:1] == port_latch[3:1])
        else $error("B C D not returned to port");
    fwd_a: assert property (func == FN_PWM && ENHANCED && !sd_force // RULE_12
        && mode_r[CFG_MSB:CFG_LSB] == CFG_FWD |-> pin_out[0] == !mode_r[1]
        && pin_out[3] == (pwm_in ^ mode_r[0]))
        else $error("forward bridge levels wrong");
    trig_a: assert property (compare_match && mode_r[SEL_MSB:0] == MS_TRIG // RULE_18
        |=> timer_reset && flags_r[FLG_UNIT] ##1 (!timer_reset || $past(compare_match)))
        else $error("special event trigger missing");
    duty_a: assert property (##1 duty_value[1:0] == $past(mode_r[DLO_MSB:DLO_LSB])) // RULE_14
        else $error("duty low bits not carried");
endmodule
`default_nettype wire

// >>> verification/epsm_drv_model.sv
`default_nettype none
module epsm_drv_model (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    output logic      [3:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-downs keep the switches off on any released pin
    assign pin_lvl = pin_out & pin_oe;
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import epsm_pkg::*;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; $display("ERROR %0t %h %h", $time, a, e); end end
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pwm_in;
    logic        period_start, cap_in, shutdown_req, awready, wready, bvalid, arready, rvalid;
    logic        compare_match, timer_reset, adc_start;
    logic [7:0]  awaddr, araddr, m, rv;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, rs;
    logic [3:0]  port_latch, port_drive, pin_out, pin_oe, pin_lvl, st;
    logic [9:0]  duty_value;
    int          n_fail, checked;
    epsm_top dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
        .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pwm_in, .period_start,
        .compare_match, .cap_in, .shutdown_req, .adc_enable(1'b0), .port_latch,
        .port_drive, .pin_out, .pin_oe, .duty_value, .capture_strobe(), .timer_reset,
        .adc_start);
    epsm_drv_model drv (.pin_out, .pin_oe, .pin_lvl);
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic stop_test();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic xfer(input bit w, input logic [7:0] a, d);
        int   i;
        logic ta, tw, tr, td;
        i = 0;
        td = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= {3{w}};
        {arvalid, rready} <= {2{!w}};
        while (!td && i < 50)
        begin
            @(negedge aclk);
            {ta, tw, tr} = {awvalid & awready, wvalid & wready, arvalid & arready};
            td = w ? bvalid : rvalid;
            rs = w ? bresp : rresp;
            rv = rdata[7:0];
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
            i++;
        end
        {bready, rready} <= 2'b00;
        if (!td) n_fail++;
        if (!td) stop_test();
    endtask
    // One-cycle pulse of compare match or of period start
    task automatic pulse(input bit cm);
        @(posedge aclk);
        {compare_match, period_start} <= {cm, !cm};
        @(posedge aclk);
        {compare_match, period_start} <= 2'b00;
    endtask
    // Steered pins follow the modulated signal, or the shutdown levels when sd is set, the rest the port latch
    task automatic stim(input int n, input logic sd);
        repeat (n)
        begin
            @(posedge aclk);
            {pwm_in, cap_in, port_latch, port_drive} <= 10'($urandom);
            @(negedge aclk);
            `CHK(pin_out & st, st & (sd ? 4'hA : {4{pwm_in}} ^ {m[0], m[1], m[0], m[1]}))
            `CHK(pin_lvl & ~st, port_latch & port_drive & ~st)
        end
    endtask
    initial
    begin
        {n_fail, checked} = '0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, period_start, shutdown_req} = '0;
        compare_match = 1'b0;
        {awaddr, araddr, wdata, pwm_in, cap_in, port_latch, port_drive} = '0;
        void'($urandom(32'hf94b));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        xfer(0, OFF_MODE, 8'h00);
        `CHK(rv, MODE_RST)
        xfer(0, OFF_STEER, 8'h00);
        `CHK(rv, STEER_RST)
        xfer(0, 8'h14, 8'h00);
        `CHK(rs, RESP_SLVERR)
        for (int k = 0; k < 4; k++)
        begin
            // drivers off until a full period
            @(posedge aclk);
            port_drive <= 4'h0;
            m = 8'h3C | 8'(k);
            st = 4'(3 * k + 5);
            xfer(1, OFF_MODE, m);
            xfer(1, OFF_STEER, {4'h0, st});
            pulse(1'b0);
            xfer(0, OFF_FLAGS, 8'h00);
            `CHK(rv[FLG_PER], k != 0)
            pulse(1'b0);
            xfer(0, OFF_FLAGS, 8'h00);
            `CHK(rv[FLG_PER], 1'b1)
            stim(4, 1'b0);
        end
        xfer(1, OFF_DUTYH, 8'hA5);
        repeat (2) @(negedge aclk);
        `CHK(duty_value, {8'hA5, 2'b11})
        // Synchronised steering waits for the period boundary
        xfer(1, OFF_STEER, 8'h1F);
        stim(3, 1'b0);
        pulse(1'b0);
        st = 4'hF;
        stim(3, 1'b0);
        xfer(1, OFF_STEER, 8'h07);
        st = 4'h7;
        stim(2, 1'b0);
        // Pin B goes high in shutdown, pins A and C low, unsteered D stays at the port latch
        xfer(1, OFF_SDCTL, 8'h01);
        shutdown_req <= 1'b1;
        stim(3, 1'b1);
        xfer(0, OFF_SDCTL, 8'h00);
        `CHK(rv[SD_STAT], 1'b1)
        xfer(1, OFF_MODE, {4'h0, MS_TRIG});
        pulse(1'b1);
        @(negedge aclk);
        `CHK({timer_reset, adc_start}, 2'b10)
        xfer(0, OFF_FLAGS, 8'h00);
        `CHK(rv[FLG_UNIT], 1'b1)
        xfer(1, OFF_MODE, {4'h0, MS_CMP_CLR});
        @(negedge aclk);
        `CHK(pin_out[0], 1'b1)
        pulse(1'b1);
        @(negedge aclk);
        `CHK(pin_out[0], 1'b0)
        stop_test();
    end
endmodule
`default_nettype wire
